// File: rtl/tam_top.sv
// thermal alarm monitor: sensor latching, alarm routing and indexed register port
`timescale 1ns/10ps
module tam_top
    import tam_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       io_sel,
    input  wire logic       io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    input  wire logic       cpu_overtemp,
    input  wire logic       deadly_switch,
    output tam_alarm_s      alarm
);
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    // pin to alarm or status: two sync edges, then one output flop
    // a read answers on the next edge and the byte stands until the next read
    // accesses may follow one another on every cycle
    // reset is synchronous; one edge with it low clears the synchronisers along with every other flop
    // limitation: a sensor pulse shorter than one clock may be missed

    // ------------------------------------------------------------
    // sensor synchronisers
    // ------------------------------------------------------------
    logic        caution_sync;
    logic        deadly_sync;
    tam_sensor_s sens;

    // socket sensor pin is asynchronous to clk
    // the first stage is read only by the second, inside tam_sync
    tam_sync u_sync_caution (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (cpu_overtemp),
        .sync_out (caution_sync)
    );

    // the fixed switch is asynchronous as well
    tam_sync u_sync_deadly (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (deadly_switch),
        .sync_out (deadly_sync)
    );

    // clean levels travel together from here on
    assign sens = '{caution: caution_sync, deadly: deadly_sync};

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    // next values are named signals feeding short flop processes
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [2:0] enable_q;
    logic [2:0] enable_d;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    tam_alarm_s alarm_q;
    tam_alarm_s alarm_d;

    // ------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------
    // strobes count only with select; both strobes in one cycle do both
    wire logic       wr_cycle  = io_sel && io_wr;
    wire logic       rd_cycle  = io_sel && io_rd;

    // port select
    wire logic       at_index  = (io_addr == TAM_PORT_INDEX);
    wire logic       at_data   = (io_addr == TAM_PORT_DATA);
    wire logic       idx_wr    = wr_cycle && at_index;
    wire logic       idx_rd    = rd_cycle && at_index;
    wire logic       dat_wr    = wr_cycle && at_data;
    wire logic       dat_rd    = rd_cycle && at_data;

    // ------------------------------------------------------------
    // index decode
    // ------------------------------------------------------------
    // data accesses follow the latched index, not the bus
    wire logic       hit_stat  = (index_q == TAM_IDX_STATUS);
    wire logic       hit_en    = (index_q == TAM_IDX_ENABLE);
    wire logic       hit_none  = !hit_stat && !hit_en;
    wire logic       stat_rd   = dat_rd && hit_stat;
    wire logic       en_rd     = dat_rd && hit_en;
    wire logic       en_wr     = dat_wr && hit_en;
    wire logic       none_rd   = dat_rd && hit_none;

    // ------------------------------------------------------------
    // index register
    // ------------------------------------------------------------
    // any byte is taken; an unmapped index simply selects nothing
    assign index_d = idx_wr ? io_wdata : index_q;

    // index flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            index_q <= TAM_INDEX_RESET;
        end else begin
            index_q <= index_d;
        end
    end

    // ------------------------------------------------------------
    // alert enable register
    // ------------------------------------------------------------
    // bit 0 routes caution to the interrupt request
    // bit 1 routes caution to the management interrupt
    // bit 2 set keeps a deadly condition from stopping the clock
    // only the three defined bits are stored; the rest are dropped
    assign enable_d = en_wr ? io_wdata[2:0] : enable_q;

    // reset leaves shutdown armed and both interrupts quiet
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_q <= TAM_ENABLE_RESET;
        end else begin
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    // bit 0 caution, bit 1 deadly; bits above read zero
    wire logic [1:0] status_set;
    wire logic [1:0] status_keep;

    // live sensor levels
    assign status_set[TAM_ST_CAUTION] = sens.caution;
    assign status_set[TAM_ST_DEADLY]  = sens.deadly;

    // a read of the status word empties it
    assign status_keep = stat_rd ? 2'h0 : status_q;
    // set wins over clear, so an event in the read cycle is never lost
    assign status_d    = status_keep | status_set;

    // status flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_q <= TAM_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reserved bits are padded with zero
    wire logic [7:0] stat_word = {6'h00, status_q};
    wire logic [7:0] en_word   = {5'h00, enable_q};

    // index reads return the latched index
    // unmapped data reads give zero; otherwise the byte stands
    assign rdata_d = idx_rd  ? index_q   :
                     stat_rd ? stat_word :
                     en_rd   ? en_word   :
                     none_rd ? 8'h00     :
                     rdata_q;

    // read data flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_q <= TAM_RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // alarm routing
    // ------------------------------------------------------------
    // sensor level already carries the hysteresis
    wire logic       caution_irq = sens.caution && enable_q[TAM_EN_IRQ];
    wire logic       caution_smi = sens.caution && enable_q[TAM_EN_SMI];
    // software owns the risk of disabling the clock stop
    wire logic       deadly_stop = sens.deadly && !enable_q[TAM_EN_NOSHUT];

    // caution drives the user warning and the fan together
    assign alarm_d.warn              = sens.caution;
    assign alarm_d.fan_on            = sens.caution;
    // enabled routes
    assign alarm_d.irq               = caution_irq;
    assign alarm_d.system_mgmt_irq_n = !caution_smi;
    assign alarm_d.clk_gen_disable   = deadly_stop;

    // alarm flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alarm_q <= TAM_ALARM_RESET;
        end else begin
            alarm_q <= alarm_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pins come straight from flops, so no decode glitch reaches them
    assign io_rdata = rdata_q;
    assign alarm    = alarm_q;
endmodule

// File: rtl/tam_pkg.sv
// package for the thermal alarm monitor: register map, field layout, reset values
package tam_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] TAM_IDX_STATUS    = 8'h02;
    localparam logic [7:0] TAM_IDX_ENABLE    = 8'h03;
    localparam logic       TAM_PORT_INDEX    = 1'b0;
    localparam logic       TAM_PORT_DATA     = 1'b1;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         TAM_ST_CAUTION    = 0;
    localparam int         TAM_ST_DEADLY     = 1;
    localparam int         TAM_EN_IRQ        = 0;
    localparam int         TAM_EN_SMI        = 1;
    localparam int         TAM_EN_NOSHUT     = 2;
    localparam logic [2:0] TAM_ENABLE_RESET  = 3'h0;
    localparam logic [7:0] TAM_INDEX_RESET   = 8'h00;
    localparam logic [1:0] TAM_STATUS_RESET  = 2'h0;
    localparam logic [7:0] TAM_RDATA_RESET   = 8'h00;
    localparam int         TAM_SYNC_STAGES   = 2;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       caution;
        logic       deadly;
    } tam_sensor_s;

    typedef struct packed {
        logic       fan_on;
        logic       warn;
        logic       irq;
        logic       system_mgmt_irq_n;
        logic       clk_gen_disable;
    } tam_alarm_s;

    // alarm levels in reset: all quiet, active-low interrupt line high
    localparam tam_alarm_s TAM_ALARM_RESET = '{fan_on: 1'b0, warn: 1'b0, irq: 1'b0,
                                                system_mgmt_irq_n: 1'b1, clk_gen_disable: 1'b0};
endpackage

// File: rtl/tam_sync.sv
// two-stage synchroniser for one level input
`timescale 1ns/10ps
module tam_sync
    import tam_pkg::*;
#(
    parameter int STAGES = TAM_SYNC_STAGES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [STAGES-1:0] chain_q;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (STAGES < 2) begin : g_bad
        $error("tam_sync needs at least two stages");
    end

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_q[STAGES-1];
endmodule

// File: testbench/tam_sensor_model.sv
// partner: socket sensor with hysteresis and a fixed deadly switch
`timescale 1ns/10ps
module tam_sensor_model #(
    parameter int TRIP_C   = 60,
    parameter int REL_C    = 58,
    parameter int DEADLY_C = 75
) (
    input  wire logic       clk,
    input  wire logic [7:0] temp_c,
    output logic            cpu_overtemp,
    output logic            deadly_switch
);
    // trip at the upper level, release only at the lower one
    always @(posedge clk) begin
        if (temp_c >= TRIP_C) cpu_overtemp <= 1'h1;
        else if (temp_c <= REL_C) cpu_overtemp <= 1'h0;
        deadly_switch <= temp_c >= DEADLY_C;
    end
endmodule

// File: testbench/tam_top_sva.sv
// checker for the thermal alarm monitor ports
`timescale 1ns/10ps
module tam_top_sva
    import tam_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       io_sel,
    input wire logic       io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       cpu_overtemp,
    input wire logic       deadly_switch,
    input tam_alarm_s      alarm
);
    logic [7:0] idx_q;
    wire        st_rd = io_sel && io_rd && io_addr && idx_q == TAM_IDX_STATUS;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // shadow of the index so data reads can be decoded here
    always_ff @(posedge clk)
        if (!reset_n) idx_q <= TAM_INDEX_RESET;
        else if (io_sel && io_wr && !io_addr) idx_q <= io_wdata;
    warn_follow_a: assert property ($past(reset_n, 3) |-> alarm.warn == $past(cpu_overtemp, 3))
        else $error("warn not following sensor");
    fan_warn_a: assert property (alarm.fan_on == alarm.warn) else $error("fan differs from warn");
    irq_route_a: assert property (alarm.irq |-> alarm.warn) else $error("irq without caution");
    smi_route_a: assert property (!alarm.system_mgmt_irq_n |-> alarm.warn) else $error("smi without caution");
    shut_cause_a: assert property (alarm.clk_gen_disable |-> $past(deadly_switch, 3))
        else $error("shutdown without deadly");
    rdata_hold_a: assert property (!(io_sel && io_rd) |=> $stable(io_rdata)) else $error("rdata moved");
    reserved_zero_a: assert property (io_sel && io_rd && io_addr |=> io_rdata[7:3] == 5'h00)
        else $error("reserved bits set");
    caution_bit_a: assert property (st_rd && alarm.warn |=> io_rdata[TAM_ST_CAUTION])
        else $error("caution bit missing");
    deadly_bit_a: assert property (st_rd && $past(reset_n, 3) && $past(deadly_switch, 3) |=> io_rdata[TAM_ST_DEADLY])
        else $error("deadly bit missing");
    cover property (st_rd && alarm.warn);
    cover property (alarm.clk_gen_disable);
    cover property (!alarm.system_mgmt_irq_n);
endmodule
bind tam_top tam_top_sva tam_top_sva_i (.*);

// File: testbench/tam_top_test.sv
// self-checking bench for the thermal alarm monitor
`timescale 1ns/10ps
module tam_top_test
    import tam_pkg::*;
;
    logic       clk, reset_n, io_sel, io_addr, io_wr, io_rd, cpu_overtemp, deadly_switch;
    logic [7:0] io_wdata, io_rdata, temp_c, d;
    tam_alarm_s alarm;
    int         bad_count = 0, check_count = 0, cyc = 0;
    tam_top tam_top_i (.*);
    tam_sensor_model tam_sensor_model_i (.*);
    task automatic chk(input string what, input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one access, then one idle cycle; data taken once settled
    task automatic acc(input logic a, w, input logic [7:0] v);
        @(posedge clk);
        {io_sel, io_addr, io_wr, io_rd, io_wdata} <= {1'h1, a, w, !w, v};
        @(posedge clk);
        {io_sel, io_wr, io_rd} <= 3'h0;
        @(negedge clk);
        d = io_rdata;
    endtask
    task automatic wreg(input logic [7:0] i, v);
        acc(1'h0, 1'h1, i);
        acc(1'h1, 1'h1, v);
    endtask
    task automatic rchk(input logic [7:0] i, e);
        acc(1'h0, 1'h1, i);
        acc(1'h1, 1'h0, 8'h00);
        chk("reg", d, e);
    endtask
    // sync plus model delay is well under six cycles
    task automatic heat(input logic [7:0] t);
        @(posedge clk);
        temp_c <= t;
        repeat (6) @(negedge clk);
    endtask
    task automatic t_regs;
        rchk(TAM_IDX_STATUS, 8'h00);
        rchk(TAM_IDX_ENABLE, 8'h00);
        acc(1'h0, 1'h0, 8'h00);
        chk("index", d, TAM_IDX_ENABLE);
        wreg(TAM_IDX_STATUS, 8'hFF);
        rchk(TAM_IDX_STATUS, 8'h00);
        wreg(TAM_IDX_ENABLE, 8'hFF);
        rchk(TAM_IDX_ENABLE, 8'h07);
        rchk(8'h05, 8'h00);
        $display("regs done");
    endtask
    task automatic t_route;
        heat(8'h50);
        for (int e = 0; e < 8; e++) begin
            wreg(TAM_IDX_ENABLE, 8'(e));
            repeat (2) @(negedge clk);
            chk("alarm", {3'h0, alarm}, {5'h03, e[0], !e[1], !e[2]});
        end
        rchk(TAM_IDX_STATUS, 8'h03);
        heat(8'h19);
        chk("alarm", {3'h0, alarm}, 8'h02);
        $display("route done");
    endtask
    task automatic t_status;
        rchk(TAM_IDX_STATUS, 8'h03);
        rchk(TAM_IDX_STATUS, 8'h00);
        heat(8'h3D);
        rchk(TAM_IDX_STATUS, 8'h01);
        rchk(TAM_IDX_STATUS, 8'h01);
        heat(8'h3B);
        chk("alarm", {3'h0, alarm}, 8'h1C);
        heat(8'h3A);
        rchk(TAM_IDX_STATUS, 8'h01);
        rchk(TAM_IDX_STATUS, 8'h00);
        $display("status done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    // hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        {reset_n, io_sel, io_addr, io_wr, io_rd, io_wdata, temp_c} = '0;
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        t_regs();
        t_route();
        t_status();
        close_out();
    end
endmodule
